//--- rtl/adc_port_pkg.sv
// Summary of operation
// - Capture the analog input level at each falling edge of the converter clock, skipping edges while the buffer is full or the converter is in standby.
// - Present each sample's result on the output bus at the second capture after its own.
// - Each result is a 10-bit parallel word, bit 0 LSB, bit 9 MSB.
// - Output coding is straight binary, zeros lowest input, ones highest.
// - Power-down high keeps standby and holds all result outputs floating.
// - Drive result outputs only when output enable and power-down are both low.
// - New word appears just after a falling edge; receiver latches relative to it.
package adc_port_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int RESULT_WIDTH = 10;
    localparam int PIPE_DEPTH   = 2;
    localparam int BUF_DEPTH    = 2;

    // ------------------------------------------------------------
    // Values after reset and the buffer-full count
    // ------------------------------------------------------------
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET  = 10'h000;
    localparam logic [1:0]              COUNT_RESET   = 2'h0;
    localparam logic [1:0]              BUF_FULL      = 2'h2;

    // ------------------------------------------------------------
    // Converter power states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        STANDBY = 1'b0,
        ACTIVE  = 1'b1
    } power_state_t;

endpackage

//--- rtl/adc_sample_output_port.sv
`timescale 1ns/1ns
module adc_sample_output_port
    import adc_port_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    convClk,
    input  wire logic [RESULT_WIDTH-1:0] analogInput,
    input  wire logic                    powerDown,
    input  wire logic                    outputEnable_n,
    output logic [RESULT_WIDTH-1:0]      resultBits,
    output logic                         resultBitsOe,
    output logic                         standby,
    output logic [RESULT_WIDTH-1:0]      streamData,
    output logic                         streamValid,
    input  wire logic                    streamReady
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    power_state_t            powerState;
    logic                    convClkPrev;
    logic                    fallEdge;
    logic                    advance;
    logic [RESULT_WIDTH-1:0] pipeWord  [PIPE_DEPTH];
    logic                    pipeValid [PIPE_DEPTH];

    sample_stream_if toBuffer ();

    // ------------------------------------------------------------
    // Converter clock edge
    // ------------------------------------------------------------

    // Clock pin is synchronous, so a plain previous-value compare suffices
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            convClkPrev <= 1'b0;
        end
        else
        begin
            convClkPrev <= convClk;
        end
    end

    assign fallEdge = convClkPrev && !convClk;

    // Full buffer stalls the pipeline: samples at those falls are skipped, held words are kept
    assign advance  = fallEdge && (powerState == ACTIVE) && toBuffer.ready;

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            powerState <= STANDBY;
        end
        else if (powerDown)
        begin
            powerState <= STANDBY;
        end
        else
        begin
            powerState <= ACTIVE;
        end
    end

    assign standby = (powerState == STANDBY);

    // ------------------------------------------------------------
    // Two-stage conversion pipeline
    // ------------------------------------------------------------

    // Straight binary pass-through; pipeline refills after standby
    always_ff @(posedge sys_clk)
    begin
        if (rst || powerState == STANDBY)
        begin
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                pipeWord[i]  <= RESULT_RESET;
                pipeValid[i] <= 1'b0;
            end
        end
        else if (advance)
        begin
            pipeWord[0]  <= analogInput;
            pipeValid[0] <= 1'b1;
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                pipeWord[i]  <= pipeWord[i-1];
                pipeValid[i] <= pipeValid[i-1];
            end
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------

    // Word leaving the last stage appears on the pins at the same edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            resultBits <= RESULT_RESET;
        end
        else if (advance)
        begin
            resultBits <= pipeWord[PIPE_DEPTH-1];
        end
    end

    // Drivers on only with enable low and not powered down
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            resultBitsOe <= 1'b0;
        end
        else
        begin
            resultBitsOe <= !outputEnable_n && !powerDown;
        end
    end

    // ------------------------------------------------------------
    // Stream path through the buffer
    // ------------------------------------------------------------

    // Only filled stages are pushed, so refill words never reach the stream
    assign toBuffer.data  = pipeWord[PIPE_DEPTH-1];
    assign toBuffer.valid = advance && pipeValid[PIPE_DEPTH-1];

    result_buffer buffer
    (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .flush      (standby),
        .fill       (toBuffer.sink),
        .drainData  (streamData),
        .drainValid (streamValid),
        .drainReady (streamReady)
    );

endmodule

//--- rtl/result_buffer.sv
`timescale 1ns/1ns
module result_buffer
    import adc_port_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    flush,
    sample_stream_if.sink                fill,
    output logic [RESULT_WIDTH-1:0]      drainData,
    output logic                         drainValid,
    input  wire logic                    drainReady
);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [RESULT_WIDTH-1:0] store [BUF_DEPTH];
    logic                    wrIdx;
    logic                    rdIdx;
    logic [1:0]              count;
    logic                    push;
    logic                    pop;

    // Honest full/empty from the occupancy count
    assign fill.ready = (count != BUF_FULL);
    assign drainValid = (count != COUNT_RESET);
    assign push       = fill.valid && fill.ready;
    assign pop        = drainValid && drainReady;
    assign drainData  = store[rdIdx];

    // Write side
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            store[wrIdx] <= fill.data;
        end
    end

    // Pointers and count; flush drops stale words on power-down
    always_ff @(posedge sys_clk)
    begin
        if (rst || flush)
        begin
            wrIdx <= 1'b0;
            rdIdx <= 1'b0;
            count <= COUNT_RESET;
        end
        else
        begin
            if (push)
            begin
                wrIdx <= ~wrIdx;
            end
            if (pop)
            begin
                rdIdx <= ~rdIdx;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

//--- rtl/sample_stream_if.sv
`timescale 1ns/1ns
// Result words handed from the pipeline into the buffer
interface sample_stream_if;
    import adc_port_pkg::*;

    logic [RESULT_WIDTH-1:0] data;
    logic                    valid;
    logic                    ready;

    modport source
    (
        output data,
        output valid,
        input  ready
    );
    modport sink
    (
        input  data,
        input  valid,
        output ready
    );
endinterface

//--- sim/adc_port_props.sv
`timescale 1ns/1ns
module adc_port_props
    import adc_port_pkg::*;
(
    input wire logic                    sys_clk,
    input wire logic                    rst,
    input wire logic                    convClk,
    input wire logic                    powerDown,
    input wire logic                    outputEnable_n,
    input wire logic [RESULT_WIDTH-1:0] resultBits,
    input wire logic                    resultBitsOe,
    input wire logic                    standby,
    input wire logic [RESULT_WIDTH-1:0] streamData,
    input wire logic                    streamValid,
    input wire logic                    streamReady
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ----------------
    // Drive and standby
    // ----------------
    oe_follow_a: assert property (!$past(rst) |-> resultBitsOe == $past(!outputEnable_n && !powerDown))
        else $error("oe lag");
    pd_float_a: assert property (powerDown |=> !resultBitsOe)
        else $error("pd drive");
    standby_track_a: assert property (!$past(rst) |-> standby == $past(powerDown))
        else $error("standby");
    flush_idle_a: assert property (standby ##1 standby |-> !streamValid)
        else $error("flush");
    // A fall while idle is ignored
    sequence idleFall;
        convClk ##1 (!convClk && standby);
    endsequence
    idle_refuse_a: assert property (idleFall |=> $stable(resultBits))
        else $error("idle fall");
    bits_hold_a: assert property ($changed(resultBits) && !$past(rst) |-> $past(convClk, 2) && !$past(convClk))
        else $error("bits move");
    stall_hold_a: assert property (streamValid && !streamReady && !powerDown && !standby |=> streamValid && $stable(streamData))
        else $error("stall");
endmodule
bind adc_sample_output_port adc_port_props u_adc_port_props (.*);

//--- sim/capture_model.sv
`timescale 1ns/1ns
// Capture side: makes the converter clock and latches words
module capture_model
    import adc_port_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    run,
    input  wire logic [RESULT_WIDTH-1:0] pins,
    output logic                         convClk,
    output logic [RESULT_WIDTH-1:0]      word,
    output logic                         wordValid
);
    logic [1:0] phase;
    logic [1:0] skip;
    // Four cycles a conversion; clock rests high so no stray fall
    always_ff @(posedge sys_clk)
    begin
        phase     <= run ? phase + 2'h1 : 2'h2;
        word      <= pins;
        wordValid <= run && phase == 2'h1 && skip == 2'h0;
        if (!run)
            skip <= 2'h2;
        else if (phase == 2'h1 && skip != 2'h0)
            skip <= skip - 2'h1;
    end
    assign convClk = phase[1];
endmodule

//--- sim/tb_adc_sample_output_port.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errCount++; $display("BAD %0t %0h", $time, a); end end
module tb_adc_sample_output_port
    import adc_port_pkg::*;
;
    logic                    sys_clk, rst, run, powerDown, outputEnable_n, streamReady, prevClk, chk;
    logic                    convClk, resultBitsOe, standby, streamValid, wordValid;
    logic [RESULT_WIDTH-1:0] analogInput, resultBits, streamData, word, pins;
    logic [RESULT_WIDTH-1:0] levels[$];
    int                      errCount, checkCount, mi, si, cycles;
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    adc_sample_output_port u_adc_sample_output_port (.*);
    // Released pins show the inverse, never a stale word
    assign pins = resultBitsOe ? resultBits : ~resultBits;
    capture_model u_capture_model (.sys_clk(sys_clk), .run(run), .pins(pins), .convClk(convClk), .word(word),
        .wordValid(wordValid));
    // Record each sampled level, judge words while chk is high and every stream word, cut hangs
    always @(posedge sys_clk)
    begin
        prevClk <= convClk;
        cycles++;
        if (prevClk && !convClk)
        begin
            levels.push_back(analogInput);
            analogInput <= analogInput + 10'h0001;
        end
        if (chk && wordValid)
        begin
            `CHK(word, levels[mi])
            mi++;
        end
        if (streamValid && streamReady)
        begin
            `CHK(streamData, levels[si])
            si++;
        end
        if (cycles == 2000)
        begin
            errCount++;
            giveVerdict();
        end
    end
    task automatic convert(input int n);
        run <= 1'b1;
        repeat (4 * n) @(posedge sys_clk);
        run <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic start(input logic ready);
        levels.delete();
        mi = 0;
        si = 0;
        streamReady <= ready;
        powerDown <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // Ramp through all-ones to zero
    task automatic t_flow();
        outputEnable_n <= 1'b0;
        chk <= 1'b1;
        start(1'b1);
        `CHK(resultBitsOe, 1'b1)
        convert(8);
        `CHK(mi, 6)
        `CHK(si, 6)
        chk <= 1'b0;
        powerDown <= 1'b1;
        // Let the power-down land before the next task drives it again
        repeat (2) @(posedge sys_clk);
        `CHK(standby, 1'b1)
    endtask
    task automatic t_modes();
        for (int i = 0; i < 4; i++)
        begin
            {powerDown, outputEnable_n} <= 2'(i);
            repeat (2) @(posedge sys_clk);
            `CHK(resultBitsOe, 1'(i == 0))
            `CHK(standby, powerDown)
        end
        convert(2);
    endtask
    // Fill until refused, then drain
    task automatic t_stall();
        start(1'b0);
        convert(6);
        `CHK(streamValid, 1'b1)
        streamReady <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(si, 2)
        `CHK(streamValid, 1'b0)
    endtask
    task automatic giveVerdict();
        if (errCount == 0 && checkCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        run = 1'b0;
        chk = 1'b0;
        prevClk = 1'b1;
        powerDown = 1'b1;
        outputEnable_n = 1'b1;
        streamReady = 1'b0;
        analogInput = 10'h03fc;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_flow();
        t_modes();
        t_stall();
        giveVerdict();
    end
endmodule
